// file: logic/scl_device.sv
// Device end of the serial configuration loader, plus its byte FIFO.
// Assumes link pins are asynchronous to clock_i and resolved by the
// link interface; loaded bytes leave on a valid/ready port.
//
// What this block does
// - Request low starts a new configuration cycle
// - Host holds request low at least 2 us
// - Load-complete and status low within 600 ns
// - Status low between 268 and 1506 us
// - Status released within 1506 us of request
// - Host waits 2 us after status rises
// - Status held low through power-on delay
// - Load-complete low before and during loading
// - Load-complete rises only after whole image
// - Host gives two falling edges after completion
// - Oscillator init reaches user mode 175-437 us
// - Startup clock: 4 periods, then 8576 cycles
// - Init clock chosen: oscillator or startup clock
// - Host keeps serial clock driven after loading
// - Passive mode samples data on rising edges
// - Data pin becomes user input after loading
// - Init-done output, once enabled, low from load-complete until user mode
// - Active mode generates clock, four rate settings
// - Chained active mode never uses fastest rate
// - Quad mode takes four bits per clock
// - Active mode launches and captures on falling edge
`include "scl_map.svh"
`default_nettype none

module scl_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clock_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	logic         wr_w;
	logic         rd_w;

	assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(D);
	assign out_valid_o = wr_q != rd_q;
	assign out_data_o  = mem_q[rd_q[AW-1:0]];
	assign wr_w        = in_valid_i & in_ready_o;
	assign rd_w        = out_valid_o & out_ready_i;

	always_ff @(posedge clock_i) begin
		if (wr_w) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(wr_w);
			rd_q <= rd_q + (AW+1)'(rd_w);
		end
	end
endmodule

module scl_device #(
	parameter int POR_CYC        = `SCL_US_CYC(`SCL_POR_US),
	parameter int STATUS_MIN_CYC = `SCL_US_CYC(`SCL_STATUS_MIN_US),
	parameter int INIT_CYC       = `SCL_US_CYC(`SCL_INIT_MIN_US),
	parameter int STARTUP_CYC    = `SCL_STARTUP_CYCLES,
	parameter int IMAGE_BYTES    = 64,
	parameter int FIFO_DEPTH     = 16
) (
	input  wire logic               clock_i,
	input  wire logic               sys_rst_i,
	scl_link_if.device              lnk,
	input  wire logic               active_serial_mode_i,
	input  wire logic               quad_i,
	input  wire scl_pkg::scl_rate_t rate_i,
	input  wire logic               chain_i,
	input  wire logic               startup_clk_en_i,
	input  wire logic               startup_clk_i,
	input  wire logic               init_done_en_i,
	output logic [7:0]              cfg_byte_o,
	output logic                    cfg_valid_o,
	input  wire logic               cfg_ready_i,
	output logic                    init_done_o,
	output logic                    user_mode_o,
	output logic                    user_data_o
);
	import scl_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int NIN = 9;
	logic [NIN-1:0] raw_w, s1_q, s2_q, s3_q, flt_q, flt_d, prv_q;

	assign raw_w = {lnk.reconfig_request_n, lnk.config_status_n,
		lnk.serial_config_clock, lnk.serial_config_data, startup_clk_i,
		lnk.flash_data_lanes};

	for (genvar i = 0; i < NIN; i++) begin : g_flt
		assign flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_q  <= `SCL_DSYNC_RST;
			s2_q  <= `SCL_DSYNC_RST;
			s3_q  <= `SCL_DSYNC_RST;
			flt_q <= `SCL_DSYNC_RST;
			prv_q <= `SCL_DSYNC_RST;
		end else begin
			s1_q  <= raw_w;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			flt_q <= flt_d;
			prv_q <= flt_q;
		end
	end

	// ----------------------------------------------------------------
	// Clock generator for active mode
	// ----------------------------------------------------------------
	function automatic logic [3:0] half_of(input scl_rate_t r,
		input logic ch);
		case (r)
		SCL_RATE_12M5: half_of = `SCL_HALF_12M5;
		SCL_RATE_25M:  half_of = `SCL_HALF_25M;
		SCL_RATE_50M:  half_of = `SCL_HALF_50M;
		default:       half_of = ch ? `SCL_HALF_50M : `SCL_HALF_100M;
		endcase
	endfunction

	scl_dev_state_t state_q, state_d;
	logic [19:0] cnt_q, cnt_d;
	logic [3:0]  div_q, half_w, bits_q, step_w, ccnt_q;
	logic [7:0]  sh_q, sh_d, cmd_q, fifo_data_w;
	logic [15:0] bytes_q;
	logic        gclk_q, gen_on_w, div_hit_w, gen_fall_w, as_w;
	logic        req_w, ps_rise_w, ps_fall_w, su_rise_w, cap_w, fall_w;
	logic        push_w, ovf_w, in_ready_w, fifo_valid_w, fifo_take_w;
	logic        cmd_done_w, drained_w, inc_w, bit_w, enter_w;
	logic        st_o_q, clk_oe_n_q, lc_q, fcmd_q, init_q, user_q, ud_q;
	logic [7:0]  byte_q;
	logic        valid_q;

	assign as_w       = active_serial_mode_i;
	assign half_w     = half_of(rate_i, chain_i);
	assign gen_on_w   = as_w & (state_q == DS_LOAD || state_q == DS_EDGES);
	assign div_hit_w  = div_q == half_w - `SCL_ONE_STEP;
	assign gen_fall_w = gen_on_w & div_hit_w & gclk_q;

	// ----------------------------------------------------------------
	// Edge events and data capture
	// ----------------------------------------------------------------
	assign req_w      = flt_q[`SCL_IN_REQ];
	assign ps_rise_w  = flt_q[`SCL_IN_CLK] & ~prv_q[`SCL_IN_CLK];
	assign ps_fall_w  = ~flt_q[`SCL_IN_CLK] & prv_q[`SCL_IN_CLK];
	assign su_rise_w  = flt_q[`SCL_IN_STARTUP] & ~prv_q[`SCL_IN_STARTUP];
	assign cmd_done_w = ccnt_q == `SCL_BYTE_BITS;
	// Edges are ignored while someone else holds status low
	assign cap_w = flt_q[`SCL_IN_STATUS] & (as_w ? gen_fall_w & cmd_done_w
		: ps_rise_w);
	assign fall_w = as_w ? gen_fall_w : ps_fall_w;
	assign bit_w  = as_w ? flt_q[0] : flt_q[`SCL_IN_DATA];
	assign step_w = (as_w & quad_i) ? `SCL_QUAD_STEP : `SCL_ONE_STEP;
	assign sh_d   = (as_w & quad_i) ? {sh_q[3:0], flt_q[3:0]}
		: {sh_q[6:0], bit_w};
	assign push_w = state_q == DS_LOAD && cap_w &&
		bits_q + step_w == `SCL_BYTE_BITS;
	assign ovf_w  = push_w & ~in_ready_w;
	assign fifo_take_w = ~valid_q | cfg_ready_i;
	assign drained_w   = ~fifo_valid_w & ~valid_q;
	assign enter_w     = state_q != DS_LOAD && state_d == DS_LOAD;

	scl_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.clock_i     (clock_i),
		.sys_rst_i   (sys_rst_i),
		.in_data_i   (sh_d),
		.in_valid_i  (push_w),
		.in_ready_o  (in_ready_w),
		.out_data_o  (fifo_data_w),
		.out_valid_o (fifo_valid_w),
		.out_ready_i (fifo_take_w)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
		DS_POR: begin
			if (cnt_q >= 20'(POR_CYC - 1)) state_d = DS_CLEAR;
		end
		DS_CLEAR: begin
			if (req_w && cnt_q >= 20'(STATUS_MIN_CYC - 1)) begin
				state_d = DS_LOAD;
			end
		end
		DS_LOAD: begin
			// Overflow is a load error: status drops, host goes idle and raises error_o
			if (ovf_w) state_d = DS_CLEAR;
			else if (push_w && bytes_q == 16'(IMAGE_BYTES - 1)) begin
				state_d = DS_DRAIN;
			end
		end
		DS_DRAIN: begin
			// Last data clock falls first; it is no start edge
			if (drained_w && !flt_q[`SCL_IN_CLK]) begin
				state_d = DS_EDGES;
			end
		end
		DS_EDGES: begin
			if (fall_w && cnt_q == 20'(`SCL_DONE_EDGES - 1)) begin
				state_d = startup_clk_en_i ? DS_CU : DS_INIT;
			end
		end
		DS_CU: begin
			if (cnt_q >= 20'(`SCL_CU_CYC - 1)) state_d = DS_INIT;
		end
		DS_INIT: begin
			if (startup_clk_en_i ? cnt_q >= 20'(STARTUP_CYC)
				: cnt_q >= 20'(INIT_CYC - 1)) begin
				state_d = DS_USER;
			end
		end
		DS_USER: state_d = DS_USER;
		default: state_d = DS_POR;
		endcase
		if (!req_w && state_q != DS_POR) state_d = DS_CLEAR;
	end

	assign inc_w = (state_q == DS_EDGES) ? fall_w :
		((state_q == DS_INIT && startup_clk_en_i) ? su_rise_w : 1'b1);
	assign cnt_d = (state_d != state_q) ? '0 :
		((inc_w && cnt_q != '1) ? cnt_q + 20'h1 : cnt_q);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= DS_POR;
			cnt_q   <= '0;
			div_q   <= '0;
			gclk_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			div_q   <= (gen_on_w && !div_hit_w) ? div_q + 4'h1 : '0;
			gclk_q  <= gen_on_w & (gclk_q ^ div_hit_w);
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sh_q    <= '0;
			bits_q  <= '0;
			bytes_q <= '0;
			cmd_q   <= '0;
			ccnt_q  <= '0;
			fcmd_q  <= 1'b1;
		end else if (enter_w) begin
			bits_q  <= '0;
			bytes_q <= '0;
			cmd_q   <= `SCL_READ_CMD;
			ccnt_q  <= '0;
		end else if (state_q == DS_LOAD) begin
			if (cap_w) begin
				sh_q   <= sh_d;
				bits_q <= push_w ? '0 : bits_q + step_w;
			end
			bytes_q <= bytes_q + 16'(push_w);
			if (as_w && gen_fall_w && !cmd_done_w) begin
				fcmd_q <= cmd_q[7];
				cmd_q  <= {cmd_q[6:0], 1'b0};
				ccnt_q <= ccnt_q + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			byte_q     <= '0;
			valid_q    <= 1'b0;
			st_o_q     <= 1'b0;
			lc_q       <= 1'b0;
			clk_oe_n_q <= 1'b1;
			init_q     <= 1'b1;
			user_q     <= 1'b0;
			ud_q       <= 1'b0;
		end else begin
			if (fifo_take_w) begin
				byte_q  <= fifo_data_w;
				valid_q <= fifo_valid_w;
			end
			st_o_q <= !(state_d == DS_POR || state_d == DS_CLEAR);
			lc_q <= state_d >= DS_EDGES && state_d <= DS_USER;
			clk_oe_n_q <= !(as_w &&
				(state_d == DS_LOAD || state_d == DS_EDGES));
			init_q <= !init_done_en_i || state_d < DS_EDGES ||
				state_d == DS_USER;
			user_q <= state_d == DS_USER;
			ud_q   <= (state_d == DS_USER) & flt_q[`SCL_IN_DATA];
		end
	end

	assign lnk.dev_status_o      = 1'b0;
	assign lnk.dev_status_oe_n   = st_o_q;
	assign lnk.load_complete     = lc_q;
	assign lnk.dev_clk_o         = gclk_q;
	assign lnk.dev_clk_oe_n      = clk_oe_n_q;
	assign lnk.flash_command_out = fcmd_q;
	assign cfg_byte_o  = byte_q;
	assign cfg_valid_o = valid_q;
	assign init_done_o = init_q;
	assign user_mode_o = user_q;
	assign user_data_o = ud_q;
endmodule

`default_nettype wire

// file: logic/scl_map.svh
// Constants of the serial configuration link: times, counts, encodings.
// Assumes a 250 MHz system clock on both ends.
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH

`define SCL_CLK_PERIOD_NS   4
`define SCL_REQ_MIN_US      2
`define SCL_STATUS_MIN_US   268
`define SCL_ST2CK_US        2
`define SCL_INIT_MIN_US     175
`define SCL_POR_US          10
`define SCL_CU_SERIAL_CONFIG_CLOCK_PERIODS 4
`define SCL_PS_MAX_MHZ      125
`define SCL_STARTUP_CYCLES  8576
`define SCL_DONE_EDGES      2
// Least times round up to whole cycles
`define SCL_US_CYC(us) \
	(((us) * 1000 + `SCL_CLK_PERIOD_NS - 1) / `SCL_CLK_PERIOD_NS)
`define SCL_CU_CYC ((`SCL_CU_SERIAL_CONFIG_CLOCK_PERIODS * 1000 / `SCL_PS_MAX_MHZ \
	+ `SCL_CLK_PERIOD_NS - 1) / `SCL_CLK_PERIOD_NS)
// Half periods of the generated clock, in system cycles
`define SCL_HALF_12M5       4'hA
`define SCL_HALF_25M        4'h5
`define SCL_HALF_50M        4'h3
`define SCL_HALF_100M       4'h2
`define SCL_READ_CMD        8'h03
`define SCL_BYTE_BITS       4'h8
`define SCL_QUAD_STEP       4'h4
`define SCL_ONE_STEP        4'h1
// Device input synchroniser bit positions and reset levels
`define SCL_IN_STARTUP      4
`define SCL_IN_DATA         5
`define SCL_IN_CLK          6
`define SCL_IN_STATUS       7
`define SCL_IN_REQ          8
`define SCL_DSYNC_RST       9'h18F
// Host synchroniser: {status, load complete, device clock}
`define SCL_HSYNC_RST       3'h4
`define SCL_HIN_CLK         0
`define SCL_HIN_LC          1
`define SCL_HIN_STATUS      2

`endif

// file: logic/scl_pkg.sv
// Types shared by both ends of the serial configuration link.
// Assumes nothing beyond the constants header.
`default_nettype none

package scl_pkg;
	typedef enum logic [1:0] {
		SCL_RATE_12M5, SCL_RATE_25M, SCL_RATE_50M, SCL_RATE_100M
	} scl_rate_t;

	typedef enum logic [2:0] {
		DS_POR, DS_CLEAR, DS_LOAD, DS_DRAIN, DS_EDGES, DS_CU, DS_INIT,
		DS_USER
	} scl_dev_state_t;

	typedef enum logic [2:0] {
		HS_IDLE, HS_PULSE, HS_WAIT_ST, HS_GAP, HS_SEND, HS_WAIT_LC,
		HS_EDGES, HS_DONE
	} scl_host_state_t;
endpackage

`default_nettype wire

// file: logic/scl_link_if.sv
// Pins between the configured device and its host or serial flash.
// Open-drain status resolves with a pull-up; the clock pin has two drivers.
`default_nettype none

interface scl_link_if;
	logic       reconfig_request_n;
	logic       dev_status_o;
	logic       dev_status_oe_n;
	logic       host_status_o;
	logic       host_status_oe_n;
	logic       config_status_n;
	logic       load_complete;
	logic       dev_clk_o;
	logic       dev_clk_oe_n;
	logic       host_clk_o;
	logic       host_clk_oe_n;
	logic       serial_config_clock;
	logic       serial_config_data;
	logic [3:0] flash_data_lanes;
	logic       flash_command_out;

	assign config_status_n = ~((~dev_status_oe_n & ~dev_status_o) |
		(~host_status_oe_n & ~host_status_o));
	assign serial_config_clock = ~dev_clk_oe_n ? dev_clk_o :
		(~host_clk_oe_n ? host_clk_o : 1'b0);

	modport device (
		input  reconfig_request_n, config_status_n, serial_config_clock,
		input  serial_config_data, flash_data_lanes,
		output dev_status_o, dev_status_oe_n, load_complete,
		output dev_clk_o, dev_clk_oe_n, flash_command_out
	);
	modport host (
		input  config_status_n, load_complete, serial_config_clock,
		input  flash_command_out,
		output reconfig_request_n, host_status_o, host_status_oe_n,
		output host_clk_o, host_clk_oe_n, serial_config_data,
		output flash_data_lanes
	);
endinterface

`default_nettype wire

// file: logic/scl_host.sv
// Host end: drives the reconfiguration request and the passive serial
// stream, or in active mode plays the serial flash answering the device.
// Assumes bytes of the image arrive on a valid/ready port.
`include "scl_map.svh"
`default_nettype none

module scl_host #(
	parameter int REQ_CYC     = `SCL_US_CYC(`SCL_REQ_MIN_US),
	parameter int GAP_CYC     = `SCL_US_CYC(`SCL_ST2CK_US),
	parameter int HALF        = 10,
	parameter int IMAGE_BYTES = 64
) (
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	scl_link_if.host        lnk,
	input  wire logic       start_i,
	input  wire logic       active_serial_mode_i,
	input  wire logic       quad_i,
	input  wire logic       hold_status_i,
	input  wire logic [7:0] byte_i,
	input  wire logic       byte_valid_i,
	output logic            byte_ready_o,
	output logic            done_o,
	output logic            error_o
);
	import scl_pkg::*;

	logic [2:0] raw_w, s1_q, s2_q, s3_q, flt_q, flt_d, prv_q;
	assign raw_w = {lnk.config_status_n, lnk.load_complete,
		lnk.serial_config_clock};
	for (genvar i = 0; i < 3; i++) begin : g_flt
		assign flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
	end

	scl_host_state_t state_q, state_d;
	logic [19:0] cnt_q;
	logic [7:0]  div_q, sh_q;
	logic [3:0]  bit_q, ccnt_q, step_w;
	logic [15:0] sent_q;
	logic        hclk_q, need_q, ready_q, req_q, data_q, hst_q;
	logic        done_q, err_q, st_w, lc_w, d_rise_w, tick_w, take_w;
	logic        run_w, rise_w, fall_w, last_w, err_w;
	logic [3:0]  lanes_q;

	assign st_w     = flt_q[`SCL_HIN_STATUS];
	assign lc_w     = flt_q[`SCL_HIN_LC];
	assign d_rise_w = flt_q[`SCL_HIN_CLK] & ~prv_q[`SCL_HIN_CLK];
	assign tick_w   = div_q == 8'(HALF - 1);
	assign take_w   = ready_q & byte_valid_i;
	assign step_w   = quad_i ? `SCL_QUAD_STEP : `SCL_ONE_STEP;
	// Clock pauses low while waiting for a byte
	assign run_w  = !active_serial_mode_i && ((state_q == HS_SEND &&
		!need_q) || state_q == HS_EDGES);
	assign rise_w = run_w & tick_w & ~hclk_q;
	assign fall_w = run_w & tick_w & hclk_q;
	assign last_w = bit_q + step_w == `SCL_BYTE_BITS;
	// Status falling mid-load means the device rejected the stream
	assign err_w  = !st_w && state_q >= HS_SEND && state_q <= HS_EDGES;

	always_comb begin
		state_d = state_q;
		case (state_q)
		HS_IDLE: if (start_i) state_d = HS_PULSE;
		HS_PULSE: if (cnt_q >= 20'(REQ_CYC - 1)) state_d = HS_WAIT_ST;
		HS_WAIT_ST: begin
			// The device clocks the flash as soon as status rises
			if (st_w && active_serial_mode_i) state_d = HS_SEND;
			else if (st_w) state_d = HS_GAP;
		end
		HS_GAP: if (cnt_q >= 20'(GAP_CYC - 1)) state_d = HS_SEND;
		HS_SEND: begin
			if (active_serial_mode_i) begin
				if (lc_w) state_d = HS_DONE;
			end else if (fall_w && last_w &&
				sent_q == 16'(IMAGE_BYTES - 1)) begin
				state_d = HS_WAIT_LC;
			end
		end
		HS_WAIT_LC: if (lc_w) state_d = HS_EDGES;
		HS_EDGES: begin
			if (fall_w && cnt_q == 20'(`SCL_DONE_EDGES - 1)) begin
				state_d = HS_DONE;
			end
		end
		HS_DONE: if (start_i) state_d = HS_PULSE;
		default: state_d = HS_IDLE;
		endcase
		if (err_w) state_d = HS_IDLE;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_q    <= `SCL_HSYNC_RST;
			s2_q    <= `SCL_HSYNC_RST;
			s3_q    <= `SCL_HSYNC_RST;
			flt_q   <= `SCL_HSYNC_RST;
			prv_q   <= `SCL_HSYNC_RST;
			state_q <= HS_IDLE;
			cnt_q   <= '0;
			div_q   <= '0;
			hclk_q  <= 1'b0;
		end else begin
			s1_q    <= raw_w;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			flt_q   <= flt_d;
			prv_q   <= flt_q;
			state_q <= state_d;
			cnt_q   <= (state_d != state_q) ? '0 :
				cnt_q + 20'(state_q != HS_EDGES || fall_w);
			div_q   <= (run_w && !tick_w) ? div_q + 8'h1 : '0;
			hclk_q  <= run_w & (hclk_q ^ tick_w);
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sh_q <= '0;
			bit_q <= '0;
			ccnt_q <= '0;
			sent_q <= '0;
			need_q <= 1'b0;
			data_q <= 1'b0;
			lanes_q <= '0;
		end else if (state_q != HS_SEND) begin
			bit_q  <= '0;
			ccnt_q <= '0;
			sent_q <= '0;
			need_q <= 1'b1;
		end else if (take_w) begin
			sh_q   <= byte_i;
			data_q <= byte_i[7];
			need_q <= 1'b0;
		end else if (fall_w) begin
			sh_q   <= {sh_q[6:0], 1'b0};
			data_q <= sh_q[6];
			bit_q  <= last_w ? '0 : bit_q + step_w;
			need_q <= last_w;
			sent_q <= sent_q + 16'(last_w);
		end else if (active_serial_mode_i && d_rise_w) begin
			if (ccnt_q != `SCL_BYTE_BITS) ccnt_q <= ccnt_q + 4'h1;
			else begin
				lanes_q <= quad_i ? sh_q[7:4] : {3'h0, sh_q[7]};
				sh_q    <= quad_i ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
				bit_q   <= last_w ? '0 : bit_q + step_w;
				need_q  <= last_w;
			end
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			req_q   <= 1'b1;
			hst_q   <= 1'b1;
			ready_q <= 1'b0;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			req_q   <= state_d != HS_PULSE;
			hst_q   <= ~hold_status_i;
			ready_q <= state_d == HS_SEND && !take_w && (need_q ||
				(fall_w && last_w)) && state_q == HS_SEND;
			done_q  <= state_d == HS_DONE;
			err_q   <= err_w | (err_q & ~start_i);
		end
	end

	assign lnk.reconfig_request_n = req_q;
	assign lnk.host_status_o      = 1'b0;
	assign lnk.host_status_oe_n   = hst_q;
	assign lnk.host_clk_o         = hclk_q;
	assign lnk.host_clk_oe_n      = active_serial_mode_i;
	assign lnk.serial_config_data = data_q;
	assign lnk.flash_data_lanes   = lanes_q;
	assign byte_ready_o = ready_q;
	assign done_o       = done_q;
	assign error_o      = err_q;
endmodule

`default_nettype wire

// file: bench/scl_link_monitor.sv
// Checker watching the pins between device and host ends.
// Assumes one clock domain and the shortened status low time.
`default_nettype none

module scl_link_monitor #(
	parameter int ST_MIN = 40
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic reconfig_request_n,
	input wire logic config_status_n,
	input wire logic load_complete,
	input wire logic serial_config_clock,
	input wire logic host_status_oe_n,
	input wire logic host_clk_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] low_q;
	logic [2:0]  edg_q;
	logic        hfall;

	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// ----
	// Helpers
	// ----
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			low_q <= '0;
			edg_q <= '0;
		end else begin
			low_q <= config_status_n ? '0 : low_q + 16'h1;
			edg_q <= !load_complete ? '0 : edg_q + {2'h0, hfall};
		end
	end
	// Only host driven edges count; active mode clock is the device's
	always_ff @(posedge clock_i) begin
		hfall <= $fell(serial_config_clock) & ~host_clk_oe_n;
	end

	sequence s_cleared;
		!config_status_n && !load_complete;
	endsequence
	sequence s_quiet8;
		(!$rose(serial_config_clock)) [*8];
	endsequence

	a_req_clears: assert property (
		$fell(reconfig_request_n) |-> ##[1:150] s_cleared)
		else $error("status or done not low after request");
	a_lc_while_st: assert property (
		!config_status_n |-> !load_complete)
		else $error("done high while status low");
	a_status_min: assert property (
		$rose(config_status_n) |-> low_q >= ST_MIN)
		else $error("status low pulse too short");
	a_status_free: assert property (
		$rose(reconfig_request_n) && host_status_oe_n
		|-> ##[1:200] config_status_n)
		else $error("status not released after request");
	a_no_clk_low: assert property (
		$rose(serial_config_clock) |-> config_status_n)
		else $error("clock edge while status low");
	a_gap_first: assert property (
		$rose(config_status_n) && !host_clk_oe_n |-> ##1 s_quiet8)
		else $error("clock too soon after status");
	a_two_edges: assert property (
		edg_q <= 3'h2)
		else $error("extra clock edges after done");
	a_lc_stands: assert property (
		load_complete && reconfig_request_n &&
		$past(reconfig_request_n, 8) |=> load_complete)
		else $error("done fell without request");
endmodule

`default_nettype wire

// file: bench/serial_config_load_handshake_bench.sv
// Testbench joining device and host ends through the link interface.
// Assumes shortened counts; both ends see the same image length.
`default_nettype none

module serial_config_load_handshake_bench;
	import scl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock_i   = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       su_clk    = 1'b0;
	logic       active    = 1'b0;
	logic       quad      = 1'b0;
	logic       su_en     = 1'b0;
	logic       idn_en    = 1'b0;
	logic       chain     = 1'b0;
	logic       hold      = 1'b0;
	logic       stall     = 1'b0;
	logic       start     = 1'b0;
	logic [3:0] run_q     = '0;
	logic [7:0] k         = '0;
	logic [7:0] got       = '0;
	logic [7:0] byte_s;
	logic       byte_valid;
	logic [7:0] cfg_byte_o;
	logic       cfg_valid_o, init_done_o, user_mode_o, user_data;
	scl_rate_t  rate      = SCL_RATE_12M5;
	localparam logic [7:0] IMG = 8'h40;
	logic       byte_ready_o, done_o, error_o;
	int         errors, comparisons, cyc;

	scl_link_if lnk ();

	scl_device #(.POR_CYC(20), .STATUS_MIN_CYC(40), .INIT_CYC(30),
		.STARTUP_CYC(16)) scl_device_i (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .lnk(lnk),
		.active_serial_mode_i(active), .quad_i(quad),
		.rate_i(rate), .chain_i(chain),
		.startup_clk_en_i(su_en), .startup_clk_i(su_clk),
		.init_done_en_i(idn_en), .cfg_byte_o(cfg_byte_o),
		.cfg_valid_o(cfg_valid_o), .cfg_ready_i(~stall),
		.init_done_o(init_done_o), .user_mode_o(user_mode_o),
		.user_data_o(user_data));
	scl_host #(.GAP_CYC(20)) scl_host_i (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .lnk(lnk),
		.start_i(start), .active_serial_mode_i(active), .quad_i(quad),
		.hold_status_i(hold), .byte_i(byte_s), .byte_valid_i(byte_valid),
		.byte_ready_o(byte_ready_o), .done_o(done_o), .error_o(error_o));
	scl_link_monitor scl_link_monitor_i (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.reconfig_request_n(lnk.reconfig_request_n),
		.config_status_n(lnk.config_status_n),
		.load_complete(lnk.load_complete),
		.serial_config_clock(lnk.serial_config_clock),
		.host_status_oe_n(lnk.host_status_oe_n),
		.host_clk_oe_n(lnk.host_clk_oe_n));

	// ----
	// Stimulus and checks
	// ----
	function automatic logic [7:0] img(input logic [3:0] r,
		input logic [7:0] i);
		return 8'hC3 ^ (i * 8'h25) ^ {r, r};
	endfunction

	assign byte_s = img(run_q, k);
	assign byte_valid = k < IMG;

	always #2 clock_i = ~clock_i;
	always #40 su_clk = ~su_clk;

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (byte_ready_o && byte_valid)
			k <= k + 8'h1;
		if (cfg_valid_o && !stall) begin
			check("config byte", cfg_byte_o, img(run_q, got));
			got <= got + 8'h1;
		end
		// Hang guard, well above four loads
		if (cyc == 60000) begin
			errors++;
			wrap_up();
		end
	end

	// Run 0 holds status, 1 uses startup clock, 2 and 3 active mode
	task automatic run(input int r);
		int n;
		int lo;
		@(posedge clock_i);
		run_q  <= r[3:0];
		k      <= '0;
		got    <= '0;
		active <= r[1];
		quad   <= (r == 3);
		su_en  <= (r == 1);
		idn_en <= (r != 2);
		chain  <= r[0];
		// Active mode needs the slowest rate; passive must ignore it
		rate   <= r[1] ? SCL_RATE_12M5 : SCL_RATE_100M;
		hold   <= (r == 0);
		stall  <= 1'b1;
		start  <= 1'b1;
		@(posedge clock_i);
		start <= 1'b0;
		repeat (200) @(posedge clock_i);
		check("status low", lnk.config_status_n, 0);
		hold <= 1'b0;
		repeat (900) @(posedge clock_i);
		stall <= 1'b0;
		for (n = 0; n < 14000 && lnk.load_complete !== 1'b1; n++)
			@(posedge clock_i);
		check("bytes taken", got, IMG);
		repeat (4) @(posedge clock_i);
		check("init done", init_done_o, !idn_en);
		lo = su_en ? 320 : 30;
		for (n = 0; n < 6000 && user_mode_o !== 1'b1; n++)
			@(posedge clock_i);
		check("init time", n + 4 >= lo, 1);
		check("user levels", {init_done_o, done_o, error_o,
			lnk.config_status_n, lnk.load_complete,
			lnk.reconfig_request_n}, 6'h37);
		check("user data", user_data, lnk.serial_config_data);
		$display("test %0d done", r);
	endtask

	initial begin
		repeat (10) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		for (int r = 0; r < 4; r++)
			run(r);
		wrap_up();
	end
endmodule

`default_nettype wire
